// *** shared/qdmc_pkg.sv ***
package qdmc_pkg;
    // ==========================================
    // sizes and software reset command
    localparam int CHANNELS = 4;
    localparam logic [7:0] SW_RESET_CMD = 8'hff;
    // ==========================================
    // timing
    localparam int CLK_FREQ_MHZ = 250;
    // keep-alive window for chip select in normal mode, microseconds
    localparam int KEEPALIVE_TIMEOUT_US = 30;
    localparam int KEEPALIVE_CYCLES = KEEPALIVE_TIMEOUT_US * CLK_FREQ_MHZ;
    // chip-select low time that wakes standby and sleep two, microseconds
    localparam int WAKE_HOLD_US = 50;
    localparam int WAKE_HOLD_CYCLES = WAKE_HOLD_US * CLK_FREQ_MHZ;
    // ==========================================
    // reset values
    localparam logic RESET_IND_CLEARED = 1'b0;
    localparam logic RESET_IND_SET = 1'b1;
    // ==========================================
    // operating modes
    typedef enum logic [2:0] {
        QDMC_RESET,
        QDMC_FAIL_SAFE,
        QDMC_NORMAL,
        QDMC_STANDBY,
        QDMC_SLEEP1,
        QDMC_SLEEP2
    } qdmc_mode_type;
endpackage : qdmc_pkg

// *** rtl/qdmc_sync.sv ***
`timescale 1ns/100ps
// ==========================================
// two-flop level synchroniser, one per bit
module qdmc_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input wire logic clk,
    input wire logic srst,
    // data
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_value,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only sync_out
    always_ff @(posedge clk) begin
        if (srst) begin
            stage1 <= reset_value;
            sync_out <= reset_value;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : qdmc_sync

// *** rtl/qdmc_output_select.sv ***
`timescale 1ns/100ps
// ==========================================
// per-channel output select
module qdmc_output_select #(
    parameter int CHANNELS = 4
) (
    // serial settings, direct inputs and pwm wave
    input wire logic [CHANNELS-1:0] serial_output_on_control,
    input wire logic [CHANNELS-1:0] direct_input_enable_control,
    input wire logic [CHANNELS-1:0] pwm_select_control,
    input wire logic [CHANNELS-1:0] direct_input_x,
    input wire logic [CHANNELS-1:0] pwm_wave,
    // result
    output logic [CHANNELS-1:0] channel_drive
);
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic request_on;
            // a high direct input requests on when enabled, else the serial bit decides; pwm select gates both
            assign request_on = (direct_input_enable_control[ch] & direct_input_x[ch])
                | serial_output_on_control[ch];
            assign channel_drive[ch] = request_on & (pwm_select_control[ch] ? pwm_wave[ch] : 1'b1);
        end
    endgenerate
endmodule : qdmc_output_select

// *** rtl/qdmc_mode_ctrl.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - reset mode at startup, on digital supply loss, or sleep one with input high
// - reset mode drives outputs from inputs, ignores serial, clears registers
// - entering reset mode clears the reset indication bit
// - reset and fail-safe always treat thermal events as auto-restart
// - reset goes fail-safe on supply good, sleep one when all inputs low
// - chip select low beyond wake hold time wakes standby or sleep two
// - normal falls to fail-safe on enable clear, keep-alive timeout, software reset
// - command byte all ones is software reset: clear registers, go fail-safe
// - fail-safe drives outputs from inputs, serial active, current monitor off
// - reset indication reads zero after reset, one after first serial access
// - unlock frame then standby zero enable one enters normal
// - unlock frame then standby one enable zero enters standby
// - normal mode drives outputs from serial settings with inputs, needs keep-alive
// - in normal each output follows its restart policy, latch or auto
// - standby drives from inputs, serial inactive, registers frozen
// - standby exits to reset, fail-safe on wake, sleep two on all inputs low
// - sleep one outputs off, registers cleared; supply good fail-safe, input high reset
// - sleep two outputs off, frozen; supply loss reset, wake fail-safe, input standby
// - battery low turns outputs off in any mode, sets battery low flag; the code sets the flag only while supply is good
// - battery recovery resumes previous mode and clears battery low flag
// - direct enable zero: serial on bit and pwm select decide off, on, pwm
// - direct enable one, input low: same as direct enable zero
module qdmc_mode_ctrl
    import qdmc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int KEEPALIVE_COUNT = KEEPALIVE_CYCLES,
    parameter int WAKE_COUNT = WAKE_HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // supplies (pins)
    input wire logic supply_good,
    input wire logic battery_low,
    // pins
    input wire logic [CHANNELS-1:0] direct_input_x,
    input wire logic chip_select_n,
    // decoded frames, same clock
    input wire logic frame_done,
    input wire logic [7:0] frame_command,
    input wire logic frame_write,
    input wire logic frame_unlock,
    input wire logic frame_low_power_request_bit,
    input wire logic frame_enable,
    input wire logic [CHANNELS-1:0] frame_serial_output_on,
    input wire logic [CHANNELS-1:0] frame_direct_input_enable,
    input wire logic [CHANNELS-1:0] frame_pwm_select,
    input wire logic [CHANNELS-1:0] frame_latch_select,
    input wire logic [CHANNELS-1:0] frame_fault_clear,
    // protection and pwm, same clock
    input wire logic [CHANNELS-1:0] thermal_fault,
    input wire logic [CHANNELS-1:0] pwm_wave,
    // outputs
    output qdmc_pkg::qdmc_mode_type mode,
    output logic [CHANNELS-1:0] output_drive,
    output logic serial_active,
    output logic load_current_monitor_output,
    output logic reset_indication,
    output logic battery_low_flag,
    output logic [CHANNELS-1:0] latched_fault
);
    import qdmc_pkg::*;

    // ==========================================
    // pin synchronisers
    logic [CHANNELS-1:0] inputs_s;
    logic cs_n_s;
    logic supply_s;
    logic batt_s;
    logic [CHANNELS-1:0] inputs_d;

    qdmc_sync #(.WIDTH(CHANNELS + 3)) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in({direct_input_x, chip_select_n, supply_good, battery_low}),
        .reset_value({{CHANNELS{1'b0}}, 3'b100}),
        .sync_out({inputs_s, cs_n_s, supply_s, batt_s})
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            inputs_d <= '0;
        end else begin
            inputs_d <= inputs_s;
        end
    end

    logic any_input_rise;
    logic all_inputs_low;
    assign any_input_rise = |(inputs_s & ~inputs_d);
    assign all_inputs_low = ~|inputs_s;

    // ==========================================
    // chip-select timers
    logic cs_n_d;
    logic [31:0] keepalive_cnt;
    logic [31:0] wake_cnt;
    logic keepalive_expired;
    logic wake_seen;
    assign keepalive_expired = (keepalive_cnt >= 32'(KEEPALIVE_COUNT));
    assign wake_seen = (wake_cnt > 32'(WAKE_COUNT));

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_n_d <= 1'b1;
        end else begin
            cs_n_d <= cs_n_s;
        end
    end

    // keep-alive restarts on every chip-select edge while in normal mode
    always_ff @(posedge clk) begin
        if (srst || mode != QDMC_NORMAL || cs_n_s != cs_n_d) begin
            keepalive_cnt <= '0;
        end else if (!keepalive_expired) begin
            keepalive_cnt <= keepalive_cnt + 32'd1;
        end
    end

    // saturates one past the hold time so wake_seen stays high until chip select rises
    always_ff @(posedge clk) begin
        if (srst || cs_n_s) begin
            wake_cnt <= '0;
        end else if (!wake_seen) begin
            wake_cnt <= wake_cnt + 32'd1;
        end
    end

    // ==========================================
    // frame decode
    logic frame_ok;
    logic sw_reset;
    logic unlock_armed;
    logic goto_normal;
    logic goto_standby;
    logic registers_clear;
    assign frame_ok = frame_done && serial_active;
    assign sw_reset = frame_ok && frame_command == SW_RESET_CMD;
    assign goto_normal = frame_ok && frame_write && unlock_armed
        && !frame_low_power_request_bit && frame_enable && !sw_reset;
    assign goto_standby = frame_ok && frame_write && unlock_armed
        && frame_low_power_request_bit && !frame_enable && !sw_reset;

    // unlock arms exactly the next frame; any frame consumes it
    always_ff @(posedge clk) begin
        if (srst || !serial_active) begin
            unlock_armed <= 1'b0;
        end else if (frame_ok) begin
            unlock_armed <= frame_write && frame_unlock && !sw_reset;
        end
    end

    // ==========================================
    // mode state machine
    qdmc_mode_type next_mode;

    always_comb begin
        next_mode = mode;
        if (!supply_s) begin
            next_mode = QDMC_RESET;
        end else begin
            unique case (mode)
                QDMC_RESET: begin
                    next_mode = QDMC_FAIL_SAFE;
                end
                QDMC_SLEEP1: begin
                    if (any_input_rise) begin
                        next_mode = QDMC_RESET;
                    end else begin
                        next_mode = QDMC_FAIL_SAFE;
                    end
                end
                QDMC_FAIL_SAFE: begin
                    if (goto_normal) begin
                        next_mode = QDMC_NORMAL;
                    end else if (goto_standby) begin
                        next_mode = QDMC_STANDBY;
                    end
                end
                QDMC_NORMAL: begin
                    if (sw_reset || keepalive_expired) begin
                        next_mode = QDMC_FAIL_SAFE;
                    end else if (goto_standby) begin
                        next_mode = QDMC_STANDBY;
                    end else if (frame_ok && frame_write && !frame_enable) begin
                        next_mode = QDMC_FAIL_SAFE;
                    end
                end
                QDMC_STANDBY: begin
                    if (wake_seen) begin
                        next_mode = QDMC_FAIL_SAFE;
                    end else if (all_inputs_low) begin
                        next_mode = QDMC_SLEEP2;
                    end
                end
                QDMC_SLEEP2: begin
                    if (wake_seen) begin
                        next_mode = QDMC_FAIL_SAFE;
                    end else if (any_input_rise) begin
                        next_mode = QDMC_STANDBY;
                    end
                end
            endcase
        end
    end

    // supply low in reset: all inputs low drops into sleep one
    qdmc_mode_type next_mode_final;
    always_comb begin
        next_mode_final = next_mode;
        if (!supply_s && mode == QDMC_RESET && all_inputs_low) begin
            next_mode_final = QDMC_SLEEP1;
        end else if (!supply_s && mode == QDMC_SLEEP1 && !any_input_rise) begin
            next_mode_final = QDMC_SLEEP1;
        end
    end

    // battery undervoltage leaves the mode untouched so it resumes on recovery
    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= QDMC_RESET;
        end else begin
            mode <= next_mode_final;
        end
    end

    // ==========================================
    // serial registers
    logic [CHANNELS-1:0] serial_output_on_control;
    logic [CHANNELS-1:0] direct_input_enable_control;
    logic [CHANNELS-1:0] pwm_select_control;
    logic [CHANNELS-1:0] channel_type_control;
    assign registers_clear = (next_mode_final == QDMC_RESET) || (next_mode_final == QDMC_SLEEP1);

    // standby and sleep two keep no frames flowing, so registers stay frozen
    always_ff @(posedge clk) begin
        if (srst || registers_clear || sw_reset) begin
            serial_output_on_control <= '0;
            direct_input_enable_control <= '0;
            pwm_select_control <= '0;
            channel_type_control <= '0;
        end else if (frame_ok && frame_write) begin
            serial_output_on_control <= frame_serial_output_on;
            direct_input_enable_control <= frame_direct_input_enable;
            pwm_select_control <= frame_pwm_select;
            channel_type_control <= frame_latch_select;
        end
    end

    // ==========================================
    // restart policy
    logic auto_restart_forced;
    assign auto_restart_forced = (mode != QDMC_NORMAL);

    // latched faults hold the channel off until cleared; set wins over clear
    always_ff @(posedge clk) begin
        if (srst || registers_clear || sw_reset) begin
            latched_fault <= '0;
        end else begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (thermal_fault[ch] && channel_type_control[ch] && !auto_restart_forced) begin
                    latched_fault[ch] <= 1'b1;
                end else if (auto_restart_forced || (frame_ok && frame_fault_clear[ch])) begin
                    latched_fault[ch] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // output drive
    logic [CHANNELS-1:0] normal_drive;
    logic [CHANNELS-1:0] next_output_drive;

    qdmc_output_select #(.CHANNELS(CHANNELS)) u_select (
        .serial_output_on_control(serial_output_on_control),
        .direct_input_enable_control(direct_input_enable_control),
        .pwm_select_control(pwm_select_control),
        .direct_input_x(inputs_s),
        .pwm_wave(pwm_wave),
        .channel_drive(normal_drive)
    );

    always_comb begin
        next_output_drive = '0;
        if (!batt_s) begin
            unique case (mode)
                QDMC_NORMAL: begin
                    next_output_drive = normal_drive & ~thermal_fault & ~latched_fault;
                end
                QDMC_RESET, QDMC_FAIL_SAFE, QDMC_STANDBY: begin
                    next_output_drive = inputs_s & ~thermal_fault;
                end
                QDMC_SLEEP1, QDMC_SLEEP2: begin
                    next_output_drive = '0;
                end
            endcase
        end
    end

    // battery low forces everything off whatever the mode
    always_ff @(posedge clk) begin
        if (srst) begin
            output_drive <= '0;
        end else begin
            output_drive <= next_output_drive;
        end
    end

    // ==========================================
    // status
    always_ff @(posedge clk) begin
        if (srst) begin
            serial_active <= 1'b0;
            load_current_monitor_output <= 1'b0;
        end else begin
            serial_active <= (next_mode_final == QDMC_FAIL_SAFE) || (next_mode_final == QDMC_NORMAL);
            load_current_monitor_output <= (next_mode_final == QDMC_NORMAL) && !batt_s;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || registers_clear) begin
            reset_indication <= RESET_IND_CLEARED;
        end else if (sw_reset) begin
            reset_indication <= RESET_IND_CLEARED;
        end else if (frame_ok) begin
            reset_indication <= RESET_IND_SET;
        end
    end

    // supply must be good for the flag; follows battery level both ways
    always_ff @(posedge clk) begin
        if (srst) begin
            battery_low_flag <= 1'b0;
        end else begin
            battery_low_flag <= batt_s && supply_s;
        end
    end
endmodule : qdmc_mode_ctrl

// *** test/qdmc_mode_ctrl_sva.sv ***
`timescale 1ns/100ps
// ==========================================
// mode controller checker
module qdmc_mode_ctrl_sva
    import qdmc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int KEEPALIVE_COUNT = 20,
    parameter int WAKE_COUNT = 30
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins and frames
    input wire logic supply_good,
    input wire logic chip_select_n,
    input wire logic frame_done,
    input wire logic [7:0] frame_command,
    input wire logic frame_write,
    input wire logic frame_unlock,
    input wire logic frame_low_power_request_bit,
    input wire logic frame_enable,
    // outputs
    input wire qdmc_pkg::qdmc_mode_type mode,
    input wire logic [CHANNELS-1:0] output_drive,
    input wire logic serial_active,
    input wire logic load_current_monitor_output,
    input wire logic reset_indication,
    input wire logic battery_low_flag
);
    // ==========================================
    // helpers
    logic [2:0] sg_hist;
    logic armed;
    logic cs_last;
    int unsigned idle;
    wire acc = frame_done && serial_active;
    // supply must have been good long enough to be past the synchroniser
    wire sg_ok = supply_good && (&sg_hist);
    always_ff @(posedge clk) sg_hist <= {sg_hist[1:0], supply_good};
    always_ff @(posedge clk) cs_last <= chip_select_n;
    always_ff @(posedge clk) begin
        if (srst || !serial_active) armed <= 1'b0;
        else if (acc) armed <= frame_write && frame_unlock && frame_command != SW_RESET_CMD;
    end
    always_ff @(posedge clk) begin
        if (srst || mode != QDMC_NORMAL || chip_select_n != cs_last) idle <= 0;
        else idle <= idle + 1;
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_after_srst: assert property ($fell(srst) |-> mode == QDMC_RESET)
        else $error("mode not reset after srst");
    a_reset_ind_clear: assert property (mode == QDMC_RESET && $past(mode) == QDMC_RESET |-> !reset_indication)
        else $error("reset indication set in reset mode");
    a_serial_follows: assert property (serial_active == (mode inside {QDMC_FAIL_SAFE, QDMC_NORMAL}))
        else $error("serial active does not follow mode");
    a_sleep_off: assert property (mode inside {QDMC_SLEEP1, QDMC_SLEEP2} && $past(mode) == mode |-> output_drive == '0)
        else $error("output on in sleep");
    a_battery_off: assert property (battery_low_flag && $past(battery_low_flag) |-> output_drive == '0)
        else $error("output on in battery low");
    a_monitor_normal: assert property (mode != QDMC_NORMAL && $past(mode) != QDMC_NORMAL |-> !load_current_monitor_output)
        else $error("current monitor outside normal");
    a_sw_reset: assert property (acc && frame_command == SW_RESET_CMD && sg_ok |=> mode == QDMC_FAIL_SAFE && !reset_indication)
        else $error("software reset not honoured");
    a_pair_normal: assert property (acc && armed && frame_write && frame_enable && !frame_low_power_request_bit
        && frame_command != SW_RESET_CMD && mode == QDMC_FAIL_SAFE && sg_ok |=> mode == QDMC_NORMAL)
        else $error("unlock pair did not enter normal");
    a_pair_standby: assert property (acc && armed && frame_write && !frame_enable && frame_low_power_request_bit
        && frame_command != SW_RESET_CMD && mode inside {QDMC_FAIL_SAFE, QDMC_NORMAL} && sg_ok |=> mode == QDMC_STANDBY)
        else $error("unlock pair did not enter standby");
    a_unlock_lost: assert property (acc && !armed && mode == QDMC_FAIL_SAFE && sg_ok |=> mode == QDMC_FAIL_SAFE)
        else $error("mode changed without unlock");
    a_keepalive_due: assert property (mode == QDMC_NORMAL |-> idle <= KEEPALIVE_COUNT + 6)
        else $error("normal kept without chip select toggle");
endmodule : qdmc_mode_ctrl_sva

bind qdmc_mode_ctrl qdmc_mode_ctrl_sva #(.CHANNELS(CHANNELS), .KEEPALIVE_COUNT(KEEPALIVE_COUNT),
    .WAKE_COUNT(WAKE_COUNT)) chk (.clk(clk), .srst(srst), .supply_good(supply_good),
    .chip_select_n(chip_select_n), .frame_done(frame_done), .frame_command(frame_command),
    .frame_write(frame_write), .frame_unlock(frame_unlock), .frame_enable(frame_enable),
    .frame_low_power_request_bit(frame_low_power_request_bit), .mode(mode), .output_drive(output_drive),
    .serial_active(serial_active), .load_current_monitor_output(load_current_monitor_output),
    .reset_indication(reset_indication), .battery_low_flag(battery_low_flag));

// *** test/qdmc_host_model.sv ***
`timescale 1ns/100ps
// ==========================================
// host model: frames and chip select
module qdmc_host_model (
    // clock
    input wire logic clk,
    // pins
    output logic chip_select_n,
    // frame strobe and fields
    output logic frame_done,
    output logic [7:0] frame_command,
    output logic frame_write,
    output logic frame_unlock,
    output logic frame_low_power_request_bit,
    output logic frame_enable,
    output logic [3:0] frame_serial_output_on,
    output logic [3:0] frame_direct_input_enable,
    output logic [3:0] frame_pwm_select
);
    logic cs_low = 1'b0;
    logic ka_en = 1'b0;
    logic ka_wave = 1'b1;
    // keep-alive runs only when asked, so a timeout can be provoked
    always begin
        #40 ka_wave = ~ka_wave;
    end
    assign chip_select_n = cs_low ? 1'b0 : (ka_en ? ka_wave : 1'b1);
    initial begin
        frame_done = 1'b0;
        {frame_command, frame_write, frame_unlock, frame_low_power_request_bit, frame_enable} = 12'h000;
        {frame_serial_output_on, frame_direct_input_enable, frame_pwm_select} = 12'h000;
    end
    // ==========================================
    // one frame: chip select low a few cycles, then a one-cycle strobe
    task automatic frame(input logic [7:0] cmd, input logic [2:0] ctl, input logic [11:0] cfg);
        @(posedge clk) #1 cs_low = 1'b1;
        repeat (4) @(posedge clk);
        #1 cs_low = 1'b0;
        frame_done = 1'b1;
        frame_write = 1'b1;
        frame_command = cmd;
        {frame_unlock, frame_low_power_request_bit, frame_enable} = ctl;
        {frame_serial_output_on, frame_direct_input_enable, frame_pwm_select} = cfg;
        @(posedge clk) #1 frame_done = 1'b0;
        // fields are not held after the strobe; inverted so stale values never look valid
        {frame_command, frame_write, frame_unlock, frame_low_power_request_bit, frame_enable} =
            ~{frame_command, frame_write, frame_unlock, frame_low_power_request_bit, frame_enable};
        {frame_serial_output_on, frame_direct_input_enable, frame_pwm_select} =
            ~{frame_serial_output_on, frame_direct_input_enable, frame_pwm_select};
    endtask : frame
    task automatic hold_low(input int n);
        @(posedge clk) #1 cs_low = 1'b1;
        repeat (n) @(posedge clk);
        #1 cs_low = 1'b0;
    endtask : hold_low
endmodule : qdmc_host_model

// *** test/qdmc_mode_ctrl_tb.sv ***
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module qdmc_mode_ctrl_tb;
    import qdmc_pkg::*;
    // ==========================================
    // signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic supply_good = 1'b0;
    logic battery_low = 1'b0;
    logic [3:0] direct_input_x = 4'h0;
    logic [3:0] pwm_wave = 4'ha;
    logic [3:0] thermal_fault = 4'h0;
    logic chip_select_n, frame_done, frame_write, frame_unlock, frame_low_power_request_bit, frame_enable;
    logic [7:0] frame_command;
    logic [3:0] frame_serial_output_on, frame_direct_input_enable, frame_pwm_select, output_drive, latched_fault;
    qdmc_mode_type mode;
    logic serial_active, load_current_monitor_output, reset_indication, battery_low_flag;
    int bad_count = 0;
    int cmp_count = 0;
    // {direct enable, input, serial on, pwm select, expected drive}
    logic [19:0] rows [6] = '{20'h0ff3e, 20'h0f0c0, 20'hf0a6a, 20'hff03e, 20'hf50c1, 20'h5f005};
    always #2 clk = ~clk;
    qdmc_mode_ctrl #(.KEEPALIVE_COUNT(20), .WAKE_COUNT(30)) uut (.clk(clk), .srst(srst),
        .supply_good(supply_good), .battery_low(battery_low), .direct_input_x(direct_input_x),
        .chip_select_n(chip_select_n), .frame_done(frame_done), .frame_command(frame_command),
        .frame_write(frame_write), .frame_unlock(frame_unlock), .frame_enable(frame_enable),
        .frame_low_power_request_bit(frame_low_power_request_bit), .frame_serial_output_on(frame_serial_output_on),
        .frame_direct_input_enable(frame_direct_input_enable), .frame_pwm_select(frame_pwm_select),
        .frame_latch_select(4'h1), .frame_fault_clear(4'h0), .thermal_fault(thermal_fault), .pwm_wave(pwm_wave),
        .mode(mode), .output_drive(output_drive), .serial_active(serial_active),
        .load_current_monitor_output(load_current_monitor_output), .reset_indication(reset_indication),
        .battery_low_flag(battery_low_flag), .latched_fault(latched_fault));
    qdmc_host_model host (.clk(clk), .chip_select_n(chip_select_n), .frame_done(frame_done),
        .frame_command(frame_command), .frame_write(frame_write), .frame_unlock(frame_unlock),
        .frame_low_power_request_bit(frame_low_power_request_bit), .frame_enable(frame_enable),
        .frame_serial_output_on(frame_serial_output_on), .frame_direct_input_enable(frame_direct_input_enable),
        .frame_pwm_select(frame_pwm_select));
    // ==========================================
    // tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic expect_mode(input qdmc_mode_type m, input int n);
        for (int i = 0; i < n && mode !== m; i++) step(1);
        `CHK(mode, m)
    endtask : expect_mode
    task automatic go_normal;
        host.ka_en = 1'b1;
        host.frame(8'h01, 3'b100, 12'h000);
        host.frame(8'h01, 3'b001, 12'h000);
        expect_mode(QDMC_NORMAL, 4);
    endtask : go_normal
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // ==========================================
    // watchdog: the sequence needs under 2000 cycles
    initial begin
        #20000;
        bad_count++;
        conclude();
    end
    // ==========================================
    // main sequence
    initial begin
        step(10);
        srst = 1'b0;
        expect_mode(QDMC_RESET, 0);
        expect_mode(QDMC_SLEEP1, 8);
        `CHK(output_drive, 4'h0)
        direct_input_x = 4'h5;
        expect_mode(QDMC_RESET, 8);
        step(3);
        `CHK(output_drive, 4'h5)
        `CHK(reset_indication, 1'b0)
        supply_good = 1'b1;
        expect_mode(QDMC_FAIL_SAFE, 8);
        direct_input_x = 4'ha;
        step(5);
        `CHK(output_drive, 4'ha)
        host.frame(8'h01, 3'b000, 12'h000);
        step(2);
        `CHK(reset_indication, 1'b1)
        host.frame(8'h01, 3'b100, 12'h000);
        host.frame(8'h01, 3'b000, 12'h000);
        host.frame(8'h01, 3'b001, 12'h000);
        expect_mode(QDMC_FAIL_SAFE, 0);
        go_normal();
        step(2);
        `CHK(load_current_monitor_output, 1'b1)
        foreach (rows[i]) begin
            direct_input_x = rows[i][15:12];
            host.frame(8'h01, 3'b001, {rows[i][11:8], rows[i][19:16], rows[i][7:4]});
            step(6);
            `CHK(output_drive, rows[i][3:0])
        end
        battery_low = 1'b1;
        step(6);
        `CHK(output_drive, 4'h0)
        `CHK(battery_low_flag, 1'b1)
        battery_low = 1'b0;
        step(6);
        `CHK(battery_low_flag, 1'b0)
        `CHK(output_drive, 4'h5)
        expect_mode(QDMC_NORMAL, 0);
        thermal_fault = 4'h3;
        step(1);
        thermal_fault = 4'h0;
        step(4);
        `CHK(output_drive, 4'h4)
        `CHK(latched_fault, 4'h1)
        host.frame(8'hff, 3'b001, 12'h000);
        expect_mode(QDMC_FAIL_SAFE, 2);
        `CHK(reset_indication, 1'b0)
        go_normal();
        host.ka_en = 1'b0;
        expect_mode(QDMC_FAIL_SAFE, 40);
        go_normal();
        host.frame(8'h01, 3'b000, 12'h000);
        expect_mode(QDMC_FAIL_SAFE, 2);
        host.ka_en = 1'b0;
        host.frame(8'h01, 3'b100, 12'h000);
        host.frame(8'h01, 3'b010, 12'h000);
        expect_mode(QDMC_STANDBY, 2);
        host.frame(8'hff, 3'b000, 12'h000);
        expect_mode(QDMC_STANDBY, 0);
        `CHK(output_drive, 4'hf)
        direct_input_x = 4'h0;
        expect_mode(QDMC_SLEEP2, 8);
        direct_input_x = 4'h2;
        expect_mode(QDMC_STANDBY, 8);
        host.hold_low(40);
        expect_mode(QDMC_FAIL_SAFE, 8);
        supply_good = 1'b0;
        expect_mode(QDMC_RESET, 8);
        step(3);
        `CHK(output_drive, 4'h2)
        conclude();
    end
endmodule : qdmc_mode_ctrl_tb
